//--- common/prog_flow_params.svh
`ifndef PROG_FLOW_PARAMS_SVH
`define PROG_FLOW_PARAMS_SVH

// Special register addresses
`define ADDR_WINDOW_0 8'h00
`define ADDR_POINTER_0 8'h01
`define ADDR_WINDOW_1 8'h02
`define ADDR_POINTER_1 8'h03
`define ADDR_BANK_SELECT 8'h04
`define ADDR_WORKING 8'h05
`define ADDR_CODE_LOW 8'h06
`define ADDR_TABLE_INDEX 8'h07
`define ADDR_TABLE_HIGH 8'h08

// General purpose data memory
`define RAM_LOW_ADDR 8'h40
`define RAM_BANK_WORDS 9'h0c0
`define RAM_DEPTH 384
`define RAM_ADDR_BITS 9
`define BANK_FIRST 8'h00
`define BANK_SECOND 8'h02
`define BANK_DISPLAY 8'h01
`define REG_RESET 8'h00

// Program memory and vectors
`define PC_BITS 13
`define VEC_RESET 13'h0000
`define VEC_EXT_FIRST 13'h0004
`define VEC_EXT_SECOND 13'h0008
`define VEC_TIMER_0 13'h000c
`define VEC_TIMER_1 13'h0010
`define VEC_SERIAL 13'h0014
`define VEC_MULTI 13'h0018
`define LAST_PAGE 5'h1f

// Instruction cycle phases
`define PH_MEM 2'h1
`define PH_READ 2'h2
`define PH_LAST 2'h3

// Return stack
`define STACK_LEVELS 5'h10
`define STACK_DEPTH 16
`define STACK_ADDR_BITS 4

`endif

//--- common/prog_flow_pkg.sv
package prog_flow_pkg;

    typedef enum logic [2:0] {
        op_none,
        op_jump,
        op_call,
        op_return_call,
        op_return_irq,
        op_skip,
        op_table_cur,
        op_table_last
    } op_t;

    typedef enum logic [1:0] {
        cyc_exec,
        cyc_dummy,
        cyc_table
    } cyc_t;

    typedef enum logic [1:0] {
        src_zero,
        src_reg,
        src_ram,
        src_disp
    } src_t;

endpackage : prog_flow_pkg

//--- rtl/data_store.sv
`timescale 1ns/100ps
`default_nettype none

module data_store #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 384,
    parameter int AW = 9
)
(
    // Clock
    input wire logic mclk_in,
    // Write side
    input wire logic we_in,
    input wire logic [AW-1:0] waddr_in,
    input wire logic [WIDTH-1:0] wdata_in,
    // Read side, registered
    input wire logic [AW-1:0] raddr_in,
    output logic [WIDTH-1:0] rdata_out
);

    logic [WIDTH-1:0] mem_q [DEPTH];

    // Read returns old contents on a same-address write
    always_ff @(posedge mclk_in)
    begin
        if (we_in)
        begin
            mem_q[waddr_in] <= wdata_in;
        end
        rdata_out <= mem_q[raddr_in];
    end

endmodule : data_store

`default_nettype wire

//--- rtl/program_flow_and_data_memory.sv
`timescale 1ns/100ps
`default_nettype none
`include "prog_flow_params.svh"

// Behaviour
// - Code pointer low write jumps within page
// - Control transfers add one dummy cycle
// - 13-bit counter addresses 8192 program words
// - Reset starts execution at 000H
// - External interrupts vector 004H and 008H
// - Timer overflows vector 00CH and 010H
// - Serial completion vectors to 014H
// - Multi-function interrupt vectors to 018H
// - Current-page table uses counter high bits
// - Last-page table forces high bits ones
// - Table low byte to memory, high latched
// - Table reads add two instruction cycles
// - Sixteen-level stack hidden from software
// - Call and interrupt push, returns pop
// - Reset empties the stack
// - Full stack holds off interrupt acknowledge
// - Call on full stack drops oldest
// - Banked general memory, shared low area
// - Unassigned low locations read zero
// - Addresses 00H and 02H access indirectly
// - Indirect to window reads zero, ignores writes
// - Second pointer also reaches display memory
// - Counter advances by one per fetch
// - Four clocks per cycle, fetch overlaps
module program_flow_and_data_memory
    import prog_flow_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Program memory
    output logic [12:0] rom_addr_out,
    input wire logic [15:0] rom_data_in,
    // Instruction issue
    output logic [15:0] instr_out,
    output logic instr_valid_out,
    output logic [1:0] phase_out,
    // Execution commands
    input wire op_t op_in,
    input wire logic [12:0] target_in,
    input wire logic [7:0] table_dest_in,
    // Data memory access
    input wire logic mem_rd_in,
    input wire logic mem_wr_in,
    input wire logic [7:0] mem_addr_in,
    input wire logic [7:0] mem_wdata_in,
    output logic [7:0] mem_rdata_out,
    // Interrupt requests, already flagged and enabled
    input wire logic irq_master_en_in,
    input wire logic [5:0] irq_pend_in,
    output logic [5:0] irq_ack_out,
    output logic stack_full_out,
    // Display memory
    output logic disp_rd_out,
    output logic disp_wr_out,
    output logic [7:0] disp_addr_out,
    output logic [7:0] disp_wdata_out,
    input wire logic [7:0] disp_rdata_in
);

    logic [1:0] ph_q;
    cyc_t cyc_q;
    logic [12:0] pc_q;
    logic [12:0] resume_pc_q;
    logic [7:0] data_pointer_0_q;
    logic [7:0] data_pointer_1_q;
    logic [7:0] ram_bank_select_q;
    logic [7:0] working_register_q;
    logic [7:0] table_index_q;
    logic [7:0] table_high_result_q;
    logic [7:0] table_dest_q;
    logic code_low_wr_q;
    logic [7:0] code_low_val_q;
    logic [3:0] stack_index_q;
    logic [4:0] stack_count_q;
    logic [4:0] stack_count_d;
    src_t rd_src_q;
    logic [7:0] rd_reg_q;

    logic last;
    logic exec;
    logic mem_go;
    logic rd_go;
    logic wr_go;
    logic table_wr;
    logic [7:0] res_addr;
    logic [7:0] res_data;
    logic [7:0] eff;
    logic via_second;
    logic window_target;
    src_t src;
    logic ram_upper;
    logic [8:0] ram_idx;
    logic [7:0] reg_val;
    logic [7:0] ram_rdata;
    logic [12:0] stack_top;
    logic stack_full;
    logic push;
    logic pop;
    logic flush;
    logic table_go;
    logic [12:0] table_addr;
    logic [12:0] nxt_pc;
    logic irq_take;
    logic [5:0] irq_pick;
    logic [12:0] irq_vec;

    assign last = (ph_q == `PH_LAST);
    assign exec = (cyc_q == cyc_exec);
    assign mem_go = exec && (ph_q == `PH_MEM);
    assign rd_go = mem_go && mem_rd_in;
    assign table_wr = last && (cyc_q == cyc_table);
    assign wr_go = (mem_go && mem_wr_in) || table_wr;
    assign stack_full = (stack_count_q == `STACK_LEVELS);

    // Phase counter, one instruction cycle per wrap
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            ph_q <= 2'h0;
        end
        else
        begin
            ph_q <= 2'(ph_q + 2'h1);
        end
    end

    assign phase_out = ph_q;

    // Address resolution, shared by instruction and table writes
    always_comb
    begin
        res_addr = (cyc_q == cyc_table) ? table_dest_q : mem_addr_in;
        res_data = (cyc_q == cyc_table) ? rom_data_in[7:0] : mem_wdata_in;
        eff = res_addr;
        via_second = 1'b0;
        window_target = 1'b0;
        if (res_addr == `ADDR_WINDOW_0)
        begin
            eff = data_pointer_0_q;
            window_target = (data_pointer_0_q == `ADDR_WINDOW_0) ||
                (data_pointer_0_q == `ADDR_WINDOW_1);
        end
        else if (res_addr == `ADDR_WINDOW_1)
        begin
            eff = data_pointer_1_q;
            via_second = 1'b1;
            window_target = (data_pointer_1_q == `ADDR_WINDOW_0) ||
                (data_pointer_1_q == `ADDR_WINDOW_1);
        end
    end

    // Target decode; the stack has no address at all
    always_comb
    begin
        src = src_zero;
        ram_upper = 1'b0;
        if (window_target)
        begin
            src = src_zero;
        end
        else if (eff < `RAM_LOW_ADDR)
        begin
            src = (eff <= `ADDR_TABLE_HIGH) ? src_reg : src_zero;
        end
        else if (via_second && (ram_bank_select_q == `BANK_DISPLAY))
        begin
            src = src_disp;
        end
        else if (ram_bank_select_q == `BANK_FIRST)
        begin
            src = src_ram;
        end
        else if (ram_bank_select_q == `BANK_SECOND)
        begin
            src = src_ram;
            ram_upper = 1'b1;
        end
    end

    assign ram_idx = 9'(eff - `RAM_LOW_ADDR) + (ram_upper ? `RAM_BANK_WORDS : 9'h000);

    always_comb
    begin
        reg_val = `REG_RESET;
        if (eff == `ADDR_POINTER_0)
        begin
            reg_val = data_pointer_0_q;
        end
        else if (eff == `ADDR_POINTER_1)
        begin
            reg_val = data_pointer_1_q;
        end
        else if (eff == `ADDR_BANK_SELECT)
        begin
            reg_val = ram_bank_select_q;
        end
        else if (eff == `ADDR_WORKING)
        begin
            reg_val = working_register_q;
        end
        else if (eff == `ADDR_CODE_LOW)
        begin
            reg_val = pc_q[7:0];
        end
        else if (eff == `ADDR_TABLE_INDEX)
        begin
            reg_val = table_index_q;
        end
        else if (eff == `ADDR_TABLE_HIGH)
        begin
            reg_val = table_high_result_q;
        end
    end

    // Special registers; the high-byte latch ignores writes
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            data_pointer_0_q <= `REG_RESET;
            data_pointer_1_q <= `REG_RESET;
            ram_bank_select_q <= `REG_RESET;
            working_register_q <= `REG_RESET;
            table_index_q <= `REG_RESET;
        end
        else if (wr_go && (src == src_reg))
        begin
            if (eff == `ADDR_POINTER_0)
            begin
                data_pointer_0_q <= res_data;
            end
            else if (eff == `ADDR_POINTER_1)
            begin
                data_pointer_1_q <= res_data;
            end
            else if (eff == `ADDR_BANK_SELECT)
            begin
                ram_bank_select_q <= res_data;
            end
            else if (eff == `ADDR_WORKING)
            begin
                working_register_q <= res_data;
            end
            else if (eff == `ADDR_TABLE_INDEX)
            begin
                table_index_q <= res_data;
            end
        end
    end

    // Code pointer low write waits for the cycle end to redirect
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            code_low_wr_q <= 1'b0;
            code_low_val_q <= `REG_RESET;
        end
        else if (mem_go && mem_wr_in && (src == src_reg) && (eff == `ADDR_CODE_LOW))
        begin
            code_low_wr_q <= 1'b1;
            code_low_val_q <= mem_wdata_in;
        end
        else if (last)
        begin
            code_low_wr_q <= 1'b0;
        end
    end

    // Table high byte, right-aligned
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            table_high_result_q <= `REG_RESET;
        end
        else if (table_wr)
        begin
            table_high_result_q <= rom_data_in[15:8];
        end
    end

    data_store #(
        .WIDTH(8),
        .DEPTH(`RAM_DEPTH),
        .AW(`RAM_ADDR_BITS)
    ) u_ram (
        .mclk_in(mclk_in),
        .we_in(wr_go && (src == src_ram) && !window_target),
        .waddr_in(ram_idx),
        .wdata_in(res_data),
        .raddr_in(ram_idx),
        .rdata_out(ram_rdata)
    );

    // Reads: source caught in phase 1, data out after phase 2
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            rd_src_q <= src_zero;
            rd_reg_q <= `REG_RESET;
            mem_rdata_out <= `REG_RESET;
        end
        else if (rd_go)
        begin
            rd_src_q <= src;
            rd_reg_q <= reg_val;
        end
        else if (ph_q == `PH_READ)
        begin
            case (rd_src_q)
                src_reg: mem_rdata_out <= rd_reg_q;
                src_ram: mem_rdata_out <= ram_rdata;
                src_disp: mem_rdata_out <= disp_rdata_in;
                default: mem_rdata_out <= `REG_RESET;
            endcase
        end
    end

    // Display memory strobes, one clock wide
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            disp_rd_out <= 1'b0;
            disp_wr_out <= 1'b0;
            disp_addr_out <= `REG_RESET;
            disp_wdata_out <= `REG_RESET;
        end
        else
        begin
            disp_rd_out <= rd_go && (src == src_disp);
            disp_wr_out <= wr_go && (src == src_disp);
            if ((rd_go || wr_go) && (src == src_disp))
            begin
                disp_addr_out <= eff;
                disp_wdata_out <= res_data;
            end
        end
    end

    // Lowest request index wins
    always_comb
    begin
        irq_pick = 6'(irq_pend_in & 6'(~irq_pend_in + 6'h01));
        case (irq_pick)
            6'h01: irq_vec = `VEC_EXT_FIRST;
            6'h02: irq_vec = `VEC_EXT_SECOND;
            6'h04: irq_vec = `VEC_TIMER_0;
            6'h08: irq_vec = `VEC_TIMER_1;
            6'h10: irq_vec = `VEC_SERIAL;
            default: irq_vec = `VEC_MULTI;
        endcase
    end

    // Next fetch address at each cycle end
    always_comb
    begin
        nxt_pc = 13'(pc_q + 13'h0001);
        flush = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        table_go = 1'b0;
        table_addr = {pc_q[12:8], table_index_q};
        irq_take = 1'b0;
        if (cyc_q == cyc_table)
        begin
            nxt_pc = resume_pc_q;
            flush = 1'b1;
        end
        else if (exec && code_low_wr_q)
        begin
            nxt_pc = {pc_q[12:8], code_low_val_q};
            flush = 1'b1;
        end
        else if (exec)
        begin
            case (op_in)
                op_jump:
                begin
                    nxt_pc = target_in;
                    flush = 1'b1;
                end
                op_call:
                begin
                    nxt_pc = target_in;
                    push = 1'b1;
                    flush = 1'b1;
                end
                op_return_call, op_return_irq:
                begin
                    nxt_pc = stack_top;
                    pop = 1'b1;
                    flush = 1'b1;
                end
                op_skip:
                begin
                    flush = 1'b1;
                end
                op_table_cur:
                begin
                    table_go = 1'b1;
                end
                op_table_last:
                begin
                    table_go = 1'b1;
                    table_addr = {`LAST_PAGE, table_index_q};
                end
                default:
                begin
                    flush = 1'b0;
                end
            endcase
        end
        // Only between ordinary instructions; a full stack holds it off
        if (irq_master_en_in && (irq_pend_in != 6'h00) && !stack_full &&
            (cyc_q != cyc_table) && !(exec && (code_low_wr_q || (op_in != op_none))))
        begin
            irq_take = 1'b1;
            push = 1'b1;
            nxt_pc = irq_vec;
            flush = 1'b1;
        end
    end

    // Sequencer; the word fetched this cycle issues at its end
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            cyc_q <= cyc_dummy;
            pc_q <= `VEC_RESET;
            rom_addr_out <= `VEC_RESET;
            resume_pc_q <= `VEC_RESET;
            table_dest_q <= `REG_RESET;
            instr_out <= 16'h0000;
            instr_valid_out <= 1'b0;
        end
        else if (last)
        begin
            if (table_go)
            begin
                cyc_q <= cyc_table;
                rom_addr_out <= table_addr;
                resume_pc_q <= pc_q;
                table_dest_q <= table_dest_in;
                instr_valid_out <= 1'b0;
            end
            else if (flush)
            begin
                cyc_q <= cyc_dummy;
                pc_q <= nxt_pc;
                rom_addr_out <= nxt_pc;
                instr_valid_out <= 1'b0;
            end
            else
            begin
                cyc_q <= cyc_exec;
                pc_q <= nxt_pc;
                rom_addr_out <= nxt_pc;
                instr_out <= rom_data_in;
                instr_valid_out <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            irq_ack_out <= 6'h00;
        end
        else
        begin
            irq_ack_out <= (last && irq_take) ? irq_pick : 6'h00;
        end
    end

    // Return stack as a ring: a push when full overwrites the oldest
    data_store #(
        .WIDTH(`PC_BITS),
        .DEPTH(`STACK_DEPTH),
        .AW(`STACK_ADDR_BITS)
    ) u_stack (
        .mclk_in(mclk_in),
        .we_in(last && push),
        .waddr_in(stack_index_q),
        .wdata_in(pc_q),
        .raddr_in(4'(stack_index_q - 4'h1)),
        .rdata_out(stack_top)
    );

    always_comb
    begin
        stack_count_d = stack_count_q;
        if (last && push && !stack_full)
        begin
            stack_count_d = 5'(stack_count_q + 5'h01);
        end
        else if (last && pop && (stack_count_q != 5'h00))
        begin
            stack_count_d = 5'(stack_count_q - 5'h01);
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            stack_index_q <= 4'h0;
            stack_count_q <= 5'h00;
            stack_full_out <= 1'b0;
        end
        else
        begin
            if (last && push)
            begin
                stack_index_q <= 4'(stack_index_q + 4'h1);
            end
            else if (last && pop)
            begin
                stack_index_q <= 4'(stack_index_q - 4'h1);
            end
            stack_count_q <= stack_count_d;
            stack_full_out <= (stack_count_d == `STACK_LEVELS);
        end
    end

endmodule : program_flow_and_data_memory

`default_nettype wire

//--- verification/program_flow_props.sv
`timescale 1ns/100ps
`default_nettype none
module program_flow_props
    import prog_flow_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Program side
    input wire logic [12:0] rom_addr_out,
    input wire logic [15:0] rom_data_in,
    input wire logic [15:0] instr_out,
    input wire logic instr_valid_out,
    input wire logic [1:0] phase_out,
    input wire op_t op_in,
    input wire logic [12:0] target_in,
    input wire logic [7:0] table_dest_in,
    // Data side
    input wire logic mem_rd_in,
    input wire logic mem_wr_in,
    input wire logic [7:0] mem_addr_in,
    input wire logic [7:0] mem_wdata_in,
    input wire logic [7:0] mem_rdata_out,
    // Interrupts and display
    input wire logic irq_master_en_in,
    input wire logic [5:0] irq_pend_in,
    input wire logic [5:0] irq_ack_out,
    input wire logic stack_full_out,
    input wire logic disp_rd_out,
    input wire logic disp_wr_out,
    input wire logic [7:0] disp_addr_out,
    input wire logic [7:0] disp_wdata_out,
    input wire logic [7:0] disp_rdata_in
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    logic pcl_wr_q;
    logic [12:0] vec_exp;
    // A pending low-byte write redirects the counter
    always_ff @(posedge mclk_in)
    begin
        if (rst_in || phase_out == 2'h3)
            pcl_wr_q <= 1'b0;
        else if (phase_out == 2'h1 && instr_valid_out && mem_wr_in && mem_addr_in == 8'h06)
            pcl_wr_q <= 1'b1;
    end
    always_comb
    begin
        vec_exp = 13'h0000;
        for (int i = 0; i < 6; i++)
            if (irq_ack_out[i])
                vec_exp = 13'(4 * (i + 1));
    end
    a_reset_vector: assert property (disable iff (1'b0) rst_in |=>
        rom_addr_out == 13'h0000 && !stack_full_out) else $error("reset state wrong");
    a_first_fetch: assert property ($fell(rst_in) |->
        (!instr_valid_out)[*4] ##1 instr_valid_out) else $error("first fetch late");
    a_phase_step: assert property (1'b1 |=>
        phase_out == $past(phase_out) + 2'h1) else $error("phase count wrong");
    a_fetch_hold: assert property (phase_out != 2'h3 |=>
        $stable(rom_addr_out) && $stable(instr_out)) else $error("fetch changed mid cycle");
    a_pc_advance: assert property (phase_out == 2'h3 && instr_valid_out && op_in == op_none
        && !pcl_wr_q && !(irq_master_en_in && irq_pend_in != 6'h00)
        |=> rom_addr_out == $past(rom_addr_out) + 13'h1) else $error("counter not advanced");
    a_jump_target: assert property (phase_out == 2'h3 && instr_valid_out
        && op_in inside {op_jump, op_call} |=> rom_addr_out == $past(target_in)
        && !instr_valid_out) else $error("jump target wrong");
    a_table_two: assert property (phase_out == 2'h3 && instr_valid_out
        && op_in inside {op_table_cur, op_table_last} && irq_pend_in == 6'h00
        |=> (!instr_valid_out)[*8] ##1 instr_valid_out) else $error("table length wrong");
    a_last_page: assert property (phase_out == 2'h3 && instr_valid_out
        && op_in == op_table_last |=> rom_addr_out[12:8] == 5'h1f) else $error("last page wrong");
    a_vector_addr: assert property (irq_ack_out != 6'h00 |->
        rom_addr_out == vec_exp) else $error("vector address wrong");
    a_ack_priority: assert property (irq_ack_out != 6'h00 |-> $past(irq_master_en_in)
        && irq_ack_out == ($past(irq_pend_in) & (~$past(irq_pend_in) + 6'h01)))
        else $error("ack not lowest pending");
    a_full_holdoff: assert property (irq_ack_out != 6'h00 |->
        !$past(stack_full_out)) else $error("ack with full stack");
    a_unused_zero: assert property (phase_out == 2'h1 && instr_valid_out && mem_rd_in
        && mem_addr_in inside {[8'h09:8'h3f]} |-> ##2 mem_rdata_out == 8'h00)
        else $error("unused location not zero");
endmodule : program_flow_props
bind program_flow_and_data_memory program_flow_props u_program_flow_props (.mclk_in, .rst_in,
    .rom_addr_out, .rom_data_in, .instr_out, .instr_valid_out, .phase_out, .op_in, .target_in,
    .table_dest_in, .mem_rd_in, .mem_wr_in, .mem_addr_in, .mem_wdata_in, .mem_rdata_out,
    .irq_master_en_in, .irq_pend_in, .irq_ack_out, .stack_full_out, .disp_rd_out, .disp_wr_out,
    .disp_addr_out, .disp_wdata_out, .disp_rdata_in);
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb;
    import prog_flow_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    op_t op_in = op_none;
    logic [12:0] target_in = 13'h0000, rom_addr_out;
    logic [7:0] table_dest_in = 8'h41;
    logic mem_rd_in = 1'b0;
    logic mem_wr_in = 1'b0;
    logic [7:0] mem_addr_in = 8'h00;
    logic [7:0] mem_wdata_in = 8'h00;
    logic irq_master_en_in = 1'b0;
    logic [5:0] irq_pend_in = 6'h00, irq_ack_out;
    logic [15:0] rom_data_in, instr_out, w;
    logic instr_valid_out, stack_full_out, disp_rd_out, disp_wr_out;
    logic [1:0] phase_out;
    logic [7:0] mem_rdata_out, disp_addr_out, disp_wdata_out, r;
    logic [17:0] dsp;
    int errors = 0, num_checks = 0, d;
    // Each word carries its own address
    assign rom_data_in = {3'h5, rom_addr_out};
    always #50 mclk_in = ~mclk_in;
    program_flow_and_data_memory u_program_flow_and_data_memory (.mclk_in, .rst_in,
        .rom_addr_out, .rom_data_in, .instr_out, .instr_valid_out, .phase_out, .op_in,
        .target_in, .table_dest_in, .mem_rd_in, .mem_wr_in, .mem_addr_in, .mem_wdata_in,
        .mem_rdata_out, .irq_master_en_in, .irq_pend_in, .irq_ack_out, .stack_full_out,
        .disp_rd_out, .disp_wr_out, .disp_addr_out, .disp_wdata_out, .disp_rdata_in(8'h5a));
    task automatic tick();
        @(posedge mclk_in);
        #10;
    endtask : tick
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report
    task automatic mem(input logic wr, input logic [7:0] a, input logic [7:0] v);
        while (!(phase_out == 2'h1 && instr_valid_out === 1'b1))
            tick();
        mem_rd_in = !wr;
        mem_wr_in = wr;
        mem_addr_in = a;
        mem_wdata_in = v;
        tick();
        mem_rd_in = 1'b0;
        mem_wr_in = 1'b0;
        dsp = {disp_wr_out, disp_rd_out, disp_addr_out, disp_wdata_out};
        tick();
        r = mem_rdata_out;
    endtask : mem
    task automatic reg_rw(input logic [7:0] a, input logic [7:0] v, input logic [7:0] e);
        mem(1'b1, a, v);
        mem(1'b0, a, 8'h00);
        `CHK("register read", e, r)
    endtask : reg_rw
    task automatic op(input op_t o, input logic [12:0] t);
        while (!(phase_out == 2'h3 && instr_valid_out === 1'b1))
            tick();
        op_in = o;
        target_in = t;
        tick();
        op_in = op_none;
    endtask : op
    // Counts dummy cycles to the next issue
    task automatic nxt();
        d = 0;
        while (!(phase_out == 2'h0 && instr_valid_out === 1'b1))
        begin
            if (phase_out == 2'h0)
                d++;
            tick();
        end
        w = instr_out;
    endtask : nxt
    task automatic take_irq(input logic [5:0] m);
        while (irq_ack_out === 6'h00)
            tick();
        `CHK("irq ack", m, irq_ack_out)
        irq_pend_in = 6'h00;
        irq_master_en_in = 1'b0;
        nxt();
    endtask : take_irq
    task automatic t_data();
        reg_rw(8'h05, 8'ha5, 8'ha5);
        reg_rw(8'h08, 8'hff, 8'h00);
        reg_rw(8'h3f, 8'h77, 8'h00);
        reg_rw(8'h40, 8'haa, 8'haa);
        reg_rw(8'h04, 8'h02, 8'h02);
        reg_rw(8'h40, 8'h55, 8'h55);
        reg_rw(8'h05, 8'ha5, 8'ha5);
        reg_rw(8'h04, 8'h00, 8'h00);
        mem(1'b0, 8'h40, 8'h00);
        `CHK("bank 0 word", 8'haa, r)
        reg_rw(8'h01, 8'h41, 8'h41);
        reg_rw(8'h00, 8'h3c, 8'h3c);
        mem(1'b0, 8'h41, 8'h00);
        `CHK("indirect target", 8'h3c, r)
        reg_rw(8'h01, 8'h02, 8'h02);
        reg_rw(8'h00, 8'h99, 8'h00);
        reg_rw(8'h04, 8'h01, 8'h01);
        reg_rw(8'h03, 8'h5e, 8'h5e);
        mem(1'b1, 8'h02, 8'hc3);
        `CHK("display write", {2'b10, 16'h5ec3}, dsp)
        mem(1'b0, 8'h02, 8'h00);
        `CHK("display read", 8'h5a, r)
        `CHK("disp strobe", {2'b01, 8'h5e}, dsp[17:8])
        reg_rw(8'h04, 8'h00, 8'h00);
    endtask : t_data
    task automatic t_flow();
        op(op_jump, 13'h0123);
        nxt();
        `CHK("jump word", {3'h5, 13'h0123}, w)
        `CHK("jump dummies", 1, d)
        op(op_skip, 13'h0000);
        nxt();
        `CHK("skip word", {3'h5, 13'h0125}, w)
        mem(1'b1, 8'h06, 8'h50);
        nxt();
        `CHK("low byte jump", {3'h5, 13'h0150}, w)
        `CHK("low byte dummies", 1, d)
        reg_rw(8'h07, 8'h34, 8'h34);
        op(op_table_cur, 13'h0000);
        nxt();
        `CHK("table dummies", 2, d)
        mem(1'b0, 8'h41, 8'h00);
        `CHK("table low", 8'h34, r)
        mem(1'b0, 8'h08, 8'h00);
        `CHK("table high", 8'ha1, r)
        op(op_table_last, 13'h0000);
        nxt();
        mem(1'b0, 8'h08, 8'h00);
        `CHK("last page high", 8'hbf, r)
    endtask : t_flow
    task automatic t_stack();
        for (int k = 0; k < 17; k++)
        begin
            op(op_call, 13'h0400 + 13'(k * 16));
            nxt();
        end
        `CHK("stack full", 1'b1, stack_full_out)
        irq_master_en_in = 1'b1;
        irq_pend_in = 6'h01;
        d = 0;
        repeat (12)
        begin
            tick();
            if (irq_ack_out !== 6'h00)
                d++;
        end
        `CHK("held off acks", 0, d)
        op(op_return_call, 13'h0000);
        take_irq(6'h01);
        `CHK("vector after pop", {3'h5, 13'h0004}, w)
        op(op_return_irq, 13'h0000);
        for (int k = 0; k < 15; k++)
        begin
            op(op_return_call, 13'h0000);
            nxt();
        end
        `CHK("oldest return", {3'h5, 13'h0401}, w)
        `CHK("stack drained", 1'b0, stack_full_out)
    endtask : t_stack
    task automatic t_vectors();
        for (int i = 0; i < 6; i++)
        begin
            irq_master_en_in = 1'b1;
            irq_pend_in = 6'(1 << i);
            take_irq(6'(1 << i));
            `CHK("vector word", {3'h5, 13'(4 * (i + 1))}, w)
            op(op_return_irq, 13'h0000);
        end
    endtask : t_vectors
    initial
    begin
        repeat (2) tick();
        `CHK("reset address", 13'h0000, rom_addr_out)
        `CHK("reset stack", 1'b0, stack_full_out)
        rst_in = 1'b0;
        nxt();
        `CHK("first word", {3'h5, 13'h0000}, w)
        repeat (4) tick();
        `CHK("phase wrap", 2'h0, phase_out)
        `CHK("next word", {3'h5, 13'h0001}, instr_out)
        t_data();
        t_flow();
        t_stack();
        t_vectors();
        final_report();
    end
    initial
    begin
        repeat (20000) @(posedge mclk_in);
        errors++;
        final_report();
    end
endmodule : tb
`default_nettype wire
